/* common/btw_map.svh */
// Constant map of the board timer and watchdog unit.
`ifndef BTW_MAP_SVH
`define BTW_MAP_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define BTW_T01_CW   24
`define BTW_T01_PW   5
`define BTW_T2_CW    8
`define BTW_T2_DW    8
`define BTW_LVL_W    3
`define BTW_VEC_W    8
`define BTW_NCH      3

// ----------------------------------------------------------------------
// Vector increments per source and reset values
// ----------------------------------------------------------------------
`define BTW_INC_T0   8'h00
`define BTW_INC_T1   8'h01
`define BTW_INC_T2   8'h02
`define BTW_RST_VEC  8'h00
`define BTW_LVL_NONE 3'h0
`define BTW_RST_SEL  2'h0

`endif

/* common/btw_pkg.sv */
// Types shared by the board timer and watchdog unit.
`include "btw_map.svh"

package btw_pkg;

    // ------------------------------------------------------------------
    // State of the top level: pending flags, watchdog failure, arbiter.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [`BTW_NCH-1:0]   pend;  // Sticky interrupt request per timer.
        logic                  fail;  // Watchdog failure line is driven.
        logic [`BTW_LVL_W-1:0] lvl;   // Level presented to the processor.
        logic [`BTW_VEC_W-1:0] vec;   // Vector presented with that level.
        logic [1:0]            sel;   // Source behind the presented level.
    } btw_top_st_t;

endpackage

/* hw/btw_chan.sv */
// One timer channel: programmable prescaler feeding a down counter.
`timescale 1ns/1ps

module btw_chan #(
    parameter int CW = 24,
    parameter int PW = 5
) (
    input  wire logic          sys_clk_in,
    input  wire logic          rst_b_in,
    input  wire logic          ce_in,
    input  wire logic          en_in,       // Counting allowed.
    input  wire logic          periodic_in, // Reload at expiry, else stop.
    input  wire logic [PW-1:0] pre_in,      // Tick every pre_in+1 clocks.
    input  wire logic [CW-1:0] reload_in,   // Period is reload_in+1 ticks.
    input  wire logic          restart_in,  // Reload and arm the counter.
    output logic               expire_out,  // One-cycle expiry pulse.
    output logic               expired_out, // Stopped at zero after expiry.
    output logic [CW-1:0]      count_out
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PW-1:0] pre;   // Prescaler down count.
        logic [CW-1:0] cnt;   // Main down count.
        logic          expd;  // Stopped; needs a restart.
        logic          pulse; // Expiry seen on the last tick.
    } btw_chan_st_t;

    btw_chan_st_t st_ff;      // Registered state.
    btw_chan_st_t nxt_st;     // Next state.
    logic         tick;       // Prescaler wraps this cycle.

    assign expire_out  = st_ff.pulse;
    assign expired_out = st_ff.expd;
    assign count_out   = st_ff.cnt;

    // Disabling freezes both counts but never touches the settings.
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.pulse = 1'b0;
        tick         = en_in && (st_ff.pre == '0);
        if (restart_in) begin
            // A restart also realigns the prescaler for an exact period.
            nxt_st.pre  = pre_in;
            nxt_st.cnt  = reload_in;
            nxt_st.expd = 1'b0;
        end else if (en_in) begin
            nxt_st.pre = tick ? pre_in : st_ff.pre - 1'b1; // R2 R3
            if (tick && !st_ff.expd) begin
                if (st_ff.cnt == '0) begin
                    nxt_st.pulse = 1'b1;
                    if (periodic_in) begin
                        nxt_st.cnt = reload_in; // R6
                    end else begin
                        nxt_st.expd = 1'b1; // R6
                    end
                end else begin
                    nxt_st.cnt = st_ff.cnt - 1'b1;
                end
            end
        end
    end

    // Reset leaves the channel stopped, so nothing fires before it is armed.
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '{pre: '0, cnt: '0, expd: 1'b1, pulse: 1'b0};
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    periodic_reload_a: assert property ( // R6
        ce_in && tick && !restart_in && !st_ff.expd && st_ff.cnt == '0 && periodic_in
        |=> st_ff.pulse && st_ff.cnt == $past(reload_in) && !st_ff.expd)
        else $error("Periodic timer did not reload at expiry.");

    stop_frozen_a: assert property ( // R8
        ce_in && !en_in && !restart_in |=> $stable(st_ff.cnt) && $stable(st_ff.pre))
        else $error("Disabled timer kept counting.");

    restart_load_a: assert property ( // R2
        ce_in && restart_in |=> st_ff.cnt == $past(reload_in) && !st_ff.expd)
        else $error("Restart did not reload the counter.");

    prescale_step_a: assert property ( // R3
        ce_in && en_in && !restart_in && st_ff.pre != '0 && !st_ff.expd
        |=> $stable(st_ff.cnt))
        else $error("Counter moved between prescaler ticks.");

    oneshot_cov_c: cover property (ce_in && tick && st_ff.cnt == '0 && !periodic_in);

endmodule

/* hw/btw_top.sv */
// Top of the board timer and watchdog unit: three timers and interrupt logic.
`timescale 1ns/1ps
`include "btw_map.svh"

// What this block does
// R1 - Three timers, each interrupting at level 1-7
// R2 - Timers 0,1: 24-bit with 5-bit prescaler
// R3 - Timer 2: 8-bit with programmable source divider
// R4 - Timer 2 expiry interrupts and drives SYSFAIL*
// R5 - Unrestarted watchdog asserts SYSFAIL* on backplane
// R6 - Every timer: watchdog or periodic interrupts
// R7 - Vector is base plus fixed source increment
// R8 - Pending until cleared; disable keeps settings
module btw_top (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic                  ce_in,
    input  wire logic                  t0_en_in,
    input  wire logic                  t0_periodic_in,
    input  wire logic [`BTW_T01_PW-1:0] t0_pre_in,
    input  wire logic [`BTW_T01_CW-1:0] t0_reload_in,
    input  wire logic                  t0_restart_in,
    input  wire logic [`BTW_LVL_W-1:0] t0_level_in,
    input  wire logic                  t1_en_in,
    input  wire logic                  t1_periodic_in,
    input  wire logic [`BTW_T01_PW-1:0] t1_pre_in,
    input  wire logic [`BTW_T01_CW-1:0] t1_reload_in,
    input  wire logic                  t1_restart_in,
    input  wire logic [`BTW_LVL_W-1:0] t1_level_in,
    input  wire logic                  t2_en_in,
    input  wire logic                  t2_periodic_in,
    input  wire logic [`BTW_T2_DW-1:0] t2_div_in,
    input  wire logic [`BTW_T2_CW-1:0] t2_reload_in,
    input  wire logic                  t2_restart_in,
    input  wire logic [`BTW_LVL_W-1:0] t2_level_in,
    input  wire logic                  wd_fail_en_in,
    input  wire logic [`BTW_VEC_W-1:0] base_vec_in,
    input  wire logic [`BTW_NCH-1:0]   tmr_clear_in,
    input  wire logic                  iack_in,
    output logic [`BTW_LVL_W-1:0]      irq_level_out,
    output logic [`BTW_VEC_W-1:0]      irq_vector_out,
    output logic [`BTW_NCH-1:0]        irq_pend_out,
    output logic [`BTW_T01_CW-1:0]     t0_count_out,
    output logic [`BTW_T01_CW-1:0]     t1_count_out,
    output logic [`BTW_T2_CW-1:0]      t2_count_out,
    output logic                       t2_expired_out,
    output logic                       sysfail_out,
    output logic                       sysfail_oe_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    btw_pkg::btw_top_st_t st_ff;                        // Registered state.
    btw_pkg::btw_top_st_t nxt_st;                       // Next state.
    logic [`BTW_NCH-1:0]                  exp;          // Expiry pulses.
    logic [`BTW_NCH-1:0][`BTW_LVL_W-1:0]  lvl;          // Level per timer.
    logic [`BTW_LVL_W-1:0]                win_lvl;      // Arbiter winner level.
    logic [1:0]                           win_sel;      // Arbiter winner index.
    logic                                 clr;          // Clear for one timer.

    // The increment of each source is fixed; software only moves the base.
    function automatic logic [`BTW_VEC_W-1:0] btw_inc(input logic [1:0] s);
        case (s)
            2'h0:    btw_inc = `BTW_INC_T0;
            2'h1:    btw_inc = `BTW_INC_T1;
            default: btw_inc = `BTW_INC_T2;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Timer channels
    // ------------------------------------------------------------------
    btw_chan #(.CW(`BTW_T01_CW), .PW(`BTW_T01_PW)) u_t0 ( // R2
        .sys_clk_in  (sys_clk_in),
        .rst_b_in    (rst_b_in),
        .ce_in       (ce_in),
        .en_in       (t0_en_in),
        .periodic_in (t0_periodic_in),
        .pre_in      (t0_pre_in),
        .reload_in   (t0_reload_in),
        .restart_in  (t0_restart_in),
        .expire_out  (exp[0]),
        .expired_out (),
        .count_out   (t0_count_out)
    );

    btw_chan #(.CW(`BTW_T01_CW), .PW(`BTW_T01_PW)) u_t1 ( // R2
        .sys_clk_in  (sys_clk_in),
        .rst_b_in    (rst_b_in),
        .ce_in       (ce_in),
        .en_in       (t1_en_in),
        .periodic_in (t1_periodic_in),
        .pre_in      (t1_pre_in),
        .reload_in   (t1_reload_in),
        .restart_in  (t1_restart_in),
        .expire_out  (exp[1]),
        .expired_out (),
        .count_out   (t1_count_out)
    );

    // The third timer's divider plays the prescaler role at its own width.
    btw_chan #(.CW(`BTW_T2_CW), .PW(`BTW_T2_DW)) u_t2 ( // R3
        .sys_clk_in  (sys_clk_in),
        .rst_b_in    (rst_b_in),
        .ce_in       (ce_in),
        .en_in       (t2_en_in),
        .periodic_in (t2_periodic_in),
        .pre_in      (t2_div_in),
        .reload_in   (t2_reload_in),
        .restart_in  (t2_restart_in),
        .expire_out  (exp[2]),
        .expired_out (t2_expired_out),
        .count_out   (t2_count_out)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign lvl            = {t2_level_in, t1_level_in, t0_level_in};
    assign irq_level_out  = st_ff.lvl;
    assign irq_vector_out = st_ff.vec;
    assign irq_pend_out   = st_ff.pend;
    // The backplane line is open drain: it is only ever pulled low.
    assign sysfail_out    = 1'b0;
    assign sysfail_oe_out = st_ff.fail;

    // ------------------------------------------------------------------
    // Pending flags, arbiter, vector and watchdog failure
    // ------------------------------------------------------------------
    // Level zero means the source is masked; ties go to the lower timer.
    always_comb begin
        nxt_st  = st_ff;
        win_lvl = `BTW_LVL_NONE;
        win_sel = `BTW_RST_SEL;
        clr     = 1'b0;
        for (int i = 0; i < `BTW_NCH; i++) begin
            if (st_ff.pend[i] && lvl[i] > win_lvl) begin // R1
                win_lvl = lvl[i];
                win_sel = 2'(i);
            end
        end
        for (int i = 0; i < `BTW_NCH; i++) begin
            // Acknowledge clears the source that was presented.
            clr = tmr_clear_in[i] ||
                  (iack_in && st_ff.lvl != `BTW_LVL_NONE && st_ff.sel == 2'(i));
            // A new expiry beats a clear in the same cycle.
            nxt_st.pend[i] = exp[i] | (st_ff.pend[i] & ~clr); // R8
        end
        nxt_st.lvl = win_lvl; // R1
        nxt_st.sel = win_sel;
        nxt_st.vec = base_vec_in + btw_inc(win_sel); // R7
        // The failure line holds until the watchdog is restarted.
        if (t2_restart_in) begin
            nxt_st.fail = 1'b0; // R5
        end
        if (exp[2] && wd_fail_en_in) begin
            nxt_st.fail = 1'b1; // R4 R5
        end
    end

    // The clock enable freezes every flag and the presented request.
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '{pend: '0, fail: 1'b0, lvl: `BTW_LVL_NONE,
                       vec: `BTW_RST_VEC, sel: `BTW_RST_SEL};
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    fail_set_a: assert property ( // R4
        ce_in && exp[2] && wd_fail_en_in |=> sysfail_oe_out)
        else $error("Watchdog expiry did not drive the failure line.");

    fail_hold_a: assert property ( // R5
        sysfail_oe_out && !(ce_in && t2_restart_in) |=> sysfail_oe_out)
        else $error("Failure line dropped without a restart.");

    fail_clear_a: assert property ( // R5
        ce_in && t2_restart_in && !exp[2] |=> !sysfail_oe_out)
        else $error("Restart did not release the failure line.");

    pend_set_a: assert property ( // R8
        ce_in && exp[0] |=> irq_pend_out[0])
        else $error("Expiry did not set the pending flag.");

    pend_hold_a: assert property ( // R8
        irq_pend_out[1] && !tmr_clear_in[1] && !iack_in |=> irq_pend_out[1])
        else $error("Pending flag lost without a clear.");

    level_idle_a: assert property ( // R1
        ce_in && irq_pend_out == 3'h0 |=> irq_level_out == `BTW_LVL_NONE)
        else $error("Level presented with nothing pending.");

    level_max_a: assert property ( // R1
        ce_in && irq_pend_out[0] |=> irq_level_out >= $past(t0_level_in))
        else $error("Presented level below a pending source.");

    // Increments are written out again so a fault in the lookup shows here.
    vector_sum_a: assert property ( // R7
        ce_in |=> irq_vector_out == $past(base_vec_in) +
            ((st_ff.sel == 2'h0) ? `BTW_INC_T0 :
             (st_ff.sel == 2'h1) ? `BTW_INC_T1 : `BTW_INC_T2))
        else $error("Vector is not base plus source increment.");

    iack_clear_a: assert property ( // R8
        ce_in && iack_in && irq_level_out != `BTW_LVL_NONE && exp == 3'h0
        |=> !irq_pend_out[$past(st_ff.sel)])
        else $error("Acknowledge left the presented source pending.");

    fail_cov_c: cover property (ce_in && exp[2] && wd_fail_en_in);
    iack_cov_c: cover property (iack_in && irq_level_out != `BTW_LVL_NONE);
    all_pend_c: cover property (irq_pend_out == 3'h7);
    clash_cov_c: cover property (ce_in && exp[1] && tmr_clear_in[1]);

endmodule

/* test/testbench.sv */
// Self-checking bench for the board timer and watchdog unit.
`timescale 1ns/1ps
`include "btw_map.svh"

module testbench;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic                     sys_clk_in = 1'b0;   // 250 MHz board clock.
    logic                     rst_b_in = 1'b0;     // Reset held low at start.
    logic                     ce_in = 1'b1;        // Tied: freeze path not targeted.
    logic [2:0]               en_v = 3'h0;         // Count enables, one per timer.
    logic [2:0]               per_v = 3'h0;        // Periodic modes, one per timer.
    logic [2:0]               rst_v = 3'h0;        // Restart pulses, one per timer.
    logic [`BTW_T01_PW-1:0]   t0_pre_in = 5'h00, t1_pre_in = 5'h00;
    logic [`BTW_T01_CW-1:0]   t0_reload_in = 24'h000000, t1_reload_in = 24'h000000;
    logic [`BTW_T2_DW-1:0]    t2_div_in = 8'h00;
    logic [`BTW_T2_CW-1:0]    t2_reload_in = 8'h00;
    logic [`BTW_LVL_W-1:0]    t0_level_in = 3'h0, t1_level_in = 3'h0, t2_level_in = 3'h0;
    logic                     wd_fail_en_in = 1'b0;
    logic [`BTW_VEC_W-1:0]    base_vec_in = 8'h40;
    logic [`BTW_NCH-1:0]      tmr_clear_in = 3'h0;
    logic                     iack_in = 1'b0;
    logic [`BTW_LVL_W-1:0]    irq_level_out;
    logic [`BTW_VEC_W-1:0]    irq_vector_out;
    logic [`BTW_NCH-1:0]      irq_pend_out;
    logic [`BTW_T01_CW-1:0]   t0_count_out, t1_count_out;
    logic [`BTW_T2_CW-1:0]    t2_count_out;
    logic                     t2_expired_out, sysfail_out, sysfail_oe_out;
    int                       err_total = 0;       // Mismatches seen.
    int                       checks_done = 0;     // Comparisons made.
    int                       cyc = 0;             // Cycle count for the hang guard.
    int                       n;                   // Measured cycle gap.

    btw_top btw_top_i (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
        .t0_en_in(en_v[0]), .t0_periodic_in(per_v[0]), .t0_pre_in(t0_pre_in),
        .t0_reload_in(t0_reload_in), .t0_restart_in(rst_v[0]), .t0_level_in(t0_level_in),
        .t1_en_in(en_v[1]), .t1_periodic_in(per_v[1]), .t1_pre_in(t1_pre_in),
        .t1_reload_in(t1_reload_in), .t1_restart_in(rst_v[1]), .t1_level_in(t1_level_in),
        .t2_en_in(en_v[2]), .t2_periodic_in(per_v[2]), .t2_div_in(t2_div_in),
        .t2_reload_in(t2_reload_in), .t2_restart_in(rst_v[2]), .t2_level_in(t2_level_in),
        .wd_fail_en_in(wd_fail_en_in), .base_vec_in(base_vec_in),
        .tmr_clear_in(tmr_clear_in), .iack_in(iack_in),
        .irq_level_out(irq_level_out), .irq_vector_out(irq_vector_out),
        .irq_pend_out(irq_pend_out), .t0_count_out(t0_count_out),
        .t1_count_out(t1_count_out), .t2_count_out(t2_count_out),
        .t2_expired_out(t2_expired_out), .sysfail_out(sysfail_out),
        .sysfail_oe_out(sysfail_oe_out));

    // ------------------------------------------------------------------
    // Clock, hang guard and shared helpers
    // ------------------------------------------------------------------
    // Half period of 2 ns gives the 4 ns board clock.
    always #2 sys_clk_in = ~sys_clk_in;

    // All scenarios fit in a few hundred cycles; a hang is cut at 20000.
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Waits k edges and samples 1 ns later, once the edge updates have landed.
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_in);
        #1;
    endtask

    // One-cycle pulse on the restart vector, launched on the next edge.
    task automatic kick(input int k);
        @(posedge sys_clk_in);
        rst_v <= 3'h1 << k;
        @(posedge sys_clk_in);
        rst_v <= 3'h0;
        #1;
    endtask

    // Bounded wait for a timer's pending flag.
    task automatic wait_pend(input int k);
        int i;
        i = 0;
        while (irq_pend_out[k] !== 1'b1 && i < 2000) begin
            tick(1);
            i++;
        end
        chk("pend_seen", {31'h0, irq_pend_out[k]}, 32'h1);
    endtask

    // Clears stale state, syncs on one expiry, clears it and counts edges to the next.
    task automatic gap(input int k, output int g);
        @(posedge sys_clk_in);
        tmr_clear_in <= 3'h1 << k;
        @(posedge sys_clk_in);
        tmr_clear_in <= 3'h0;
        tick(1);
        wait_pend(k);
        g = 0;
        do begin
            @(posedge sys_clk_in);
            tmr_clear_in <= (g == 0) ? (3'h1 << k) : 3'h0;
            g++;
            #1;
        end while ((g < 3 || irq_pend_out[k] !== 1'b1) && g < 600);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Full-width reloads land in the counters; disabled timers hold them.
    task automatic t_reload;
        @(posedge sys_clk_in);
        t0_reload_in <= 24'h800013;
        t1_reload_in <= 24'hffffff;
        t2_reload_in <= 8'hff;
        kick(0);
        kick(1);
        kick(2);
        tick(3);
        chk("t0_count", t0_count_out, 32'h800013);
        chk("t1_count", t1_count_out, 32'hffffff);
        chk("t2_count", t2_count_out, 32'hff);
    endtask

    // Periodic timer 0, exact period, level/vector, and disable keeping the prescaler.
    task automatic t_periodic0;
        logic [31:0] c;
        @(posedge sys_clk_in);
        t0_pre_in <= 5'h03;
        t0_reload_in <= 24'h000004;
        t0_level_in <= 3'h5;
        per_v[0] <= 1'b1;
        en_v[0] <= 1'b1;
        kick(0);
        gap(0, n);
        chk("t0_period", n, 32'h14);
        tick(2);
        chk("t0_level", irq_level_out, 32'h5);
        chk("t0_vector", irq_vector_out, 32'h40);
        @(posedge sys_clk_in);
        en_v[0] <= 1'b0;
        tick(2);
        c = t0_count_out;
        tick(10);
        chk("t0_frozen", t0_count_out, c);
        @(posedge sys_clk_in);
        en_v[0] <= 1'b1;
        gap(0, n);
        chk("t0_period_kept", n, 32'h14);
        @(posedge sys_clk_in);
        en_v[0] <= 1'b0;
        tmr_clear_in <= 3'h1;
        @(posedge sys_clk_in);
        tmr_clear_in <= 3'h0;
    endtask

    // Timer 1 at the largest prescale, then pending stays until acknowledged.
    task automatic t_periodic1;
        @(posedge sys_clk_in);
        t1_pre_in <= 5'h1f;
        t1_reload_in <= 24'h000001;
        t1_level_in <= 3'h7;
        per_v[1] <= 1'b1;
        en_v[1] <= 1'b1;
        kick(1);
        gap(1, n);
        chk("t1_period", n, 32'h40);
        @(posedge sys_clk_in);
        en_v[1] <= 1'b0;
        tick(20);
        chk("t1_sticky", irq_pend_out, 32'h2);
        chk("t1_vector", irq_vector_out, 32'h41);
        chk("t1_level", irq_level_out, 32'h7);
        @(posedge sys_clk_in);
        iack_in <= 1'b1;
        @(posedge sys_clk_in);
        iack_in <= 1'b0;
        tick(3);
        chk("t1_acked", irq_pend_out, 32'h0);
        chk("t1_idle", irq_level_out, 32'h0);
    endtask

    // One-shot timers 0 and 1 pending together: highest level wins, mask by level 0.
    task automatic t_priority;
        @(posedge sys_clk_in);
        t0_pre_in <= 5'h00;
        t0_reload_in <= 24'h000002;
        t0_level_in <= 3'h3;
        t1_pre_in <= 5'h00;
        t1_reload_in <= 24'h000002;
        t1_level_in <= 3'h6;
        per_v[1:0] <= 2'h0;
        en_v[1:0] <= 2'h3;
        kick(0);
        kick(1);
        tick(12);
        chk("both_pend", irq_pend_out, 32'h3);
        chk("hi_level", irq_level_out, 32'h6);
        chk("hi_vector", irq_vector_out, 32'h41);
        @(posedge sys_clk_in);
        iack_in <= 1'b1;
        @(posedge sys_clk_in);
        iack_in <= 1'b0;
        tick(3);
        chk("lo_level", irq_level_out, 32'h3);
        chk("lo_vector", irq_vector_out, 32'h40);
        t0_level_in <= 3'h0;
        tick(3);
        chk("masked", irq_level_out, 32'h0);
        chk("still_pend", irq_pend_out, 32'h1);
        @(posedge sys_clk_in);
        tmr_clear_in <= 3'h1;
        @(posedge sys_clk_in);
        tmr_clear_in <= 3'h0;
        en_v[1:0] <= 2'h0;
    endtask

    // Timer 2 as watchdog: kicked it stays quiet, left alone it pulls the fail line.
    task automatic t_watchdog;
        @(posedge sys_clk_in);
        t2_div_in <= 8'h01;
        t2_reload_in <= 8'h03;
        t2_level_in <= 3'h2;
        base_vec_in <= 8'hfe;
        wd_fail_en_in <= 1'b1;
        en_v[2] <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            kick(2);
            tick(3);
            chk("wd_quiet", sysfail_oe_out, 32'h0);
        end
        kick(2);
        n = 1;
        while (sysfail_oe_out !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        // Expiry lands 8 edges after the restart edge, the line one edge later.
        chk("wd_fire_time", n, 32'h0a);
        chk("wd_expired", t2_expired_out, 32'h1);
        chk("wd_data", sysfail_out, 32'h0);
        tick(3);
        chk("wd_level", irq_level_out, 32'h2);
        chk("wd_vector", irq_vector_out, 32'h00);
        kick(2);
        tick(1);
        chk("wd_released", sysfail_oe_out, 32'h0);
        @(posedge sys_clk_in);
        wd_fail_en_in <= 1'b0;
        per_v[2] <= 1'b1;
        t2_div_in <= 8'h02;
        t2_reload_in <= 8'h04;
        kick(2);
        gap(2, n);
        chk("t2_period", n, 32'h0f);
        chk("t2_no_fail", sysfail_oe_out, 32'h0);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and verdict
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Reset is held three cycles; afterwards every output sits at its idle value.
    task automatic t_reset;
        repeat (3) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        tick(2);
        chk("rst_pend", irq_pend_out, 32'h0);
        chk("rst_level", irq_level_out, 32'h0);
        chk("rst_expired", t2_expired_out, 32'h1);
        chk("rst_fail", sysfail_oe_out, 32'h0);
    endtask

    initial begin
        t_reset();
        t_reload();
        t_periodic0();
        t_periodic1();
        t_priority();
        t_watchdog();
        test_done();
    end
endmodule
